// ### hdl/sac_pkg.sv
// Constants, register map and types of the successive-approximation converter control.

`default_nettype none

package sac_pkg;

  // ****************************************************************
  // Register map: printed offsets are indices, byte address is 4x.
  // ****************************************************************
  localparam int unsigned ADDR_W            = 12;            // APB address width.
  localparam logic [9:0]  IDX_RESULT        = 10'h070;       // Conversion result index.
  localparam logic [9:0]  IDX_CONTROL       = 10'h071;       // Control and status index.
  localparam logic [9:0]  IDX_IRQ_STATUS    = 10'h072;       // Sticky event status index.
  localparam logic [9:0]  IDX_IRQ_CLEAR     = 10'h073;       // Event clear index.
  localparam logic [9:0]  IDX_IRQ_ENABLE    = 10'h074;       // Event enable index.
  localparam logic [11:0] ADDR_RESULT       = {IDX_RESULT, 2'b00};
  localparam logic [11:0] ADDR_CONTROL      = {IDX_CONTROL, 2'b00};
  localparam logic [11:0] ADDR_IRQ_STATUS   = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] ADDR_IRQ_CLEAR    = {IDX_IRQ_CLEAR, 2'b00};
  localparam logic [11:0] ADDR_IRQ_ENABLE   = {IDX_IRQ_ENABLE, 2'b00};

  // ****************************************************************
  // Field positions and reset values.
  // ****************************************************************
  localparam int unsigned BIT_COMPLETE      = 7;             // Completion flag.
  localparam int unsigned BIT_POWER_ON      = 5;             // Converter power-on bit.
  localparam int unsigned CHAN_W            = 3;             // Channel select width.
  localparam int unsigned IRQ_W             = 2;             // Number of event bits.
  localparam int unsigned IRQ_SETTLED       = 0;             // Stabilization finished.
  localparam int unsigned IRQ_ABORTED       = 1;             // Conversion aborted by write.
  localparam logic [7:0]  RESET_RESULT      = 8'h00;         // Result after reset.
  localparam logic [7:0]  TRIAL_FIRST       = 8'h80;         // First trial code.

  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_PS     = 5000;          // 200 MHz clock.
  localparam int unsigned STAB_TIME_NS      = 30000;         // Typical settle time.
  localparam int unsigned STAB_CYCLES       = STAB_TIME_NS * 1000 / CLK_PERIOD_PS;
  localparam int unsigned STAB_W            = 16;            // Settle counter width.
  localparam logic [5:0]  CONV_LAST         = 6'h3f;         // 64 cycles per conversion.
  localparam int unsigned SAMPLE_HALF       = 63;            // 31.5 cycles in half cycles.
  localparam logic [5:0]  SAMPLE_LAST       = 6'((SAMPLE_HALF + 1) / 2 - 1);
  localparam logic [1:0]  TRIAL_LAST        = 2'h3;          // 4 cycles per trial bit.

  // Converter sequencer states, Gray coded along off, settle, sample, convert.
  typedef enum logic [1:0] {
    SAC_OFF     = 2'b00,
    SAC_SETTLE  = 2'b01,
    SAC_SAMPLE  = 2'b11,
    SAC_CONVERT = 2'b10
  } sac_state_type;

endpackage : sac_pkg

`default_nettype wire

// ### hdl/sac_adc_ctrl.sv
// Control logic of the 8-bit eight-channel successive-approximation converter.
`timescale 1ns/1ps
`default_nettype none

module sac_adc_ctrl #(
  parameter int unsigned STAB_CYCLES = sac_pkg::STAB_CYCLES
) (
  input  wire logic        ref_clk,            // 200 MHz clock.
  input  wire logic        reset_n,            // Asynchronous reset, active low.
  input  wire logic        psel,               // APB select.
  input  wire logic        penable,            // APB access phase.
  input  wire logic        pwrite,             // APB direction, high for write.
  input  wire logic [11:0] paddr,              // APB byte address.
  input  wire logic [31:0] pwdata,             // APB write data.
  input  wire logic [3:0]  pstrb,              // APB byte strobes.
  output logic      [31:0] prdata,             // APB read data.
  output logic             pready,             // APB ready.
  output logic             pslverr,            // APB error on unmapped address.
  input  wire logic        halt_mode,          // Chip is in halt mode.
  input  wire logic        cmp_above,          // Input at or above the trial level.
  output logic             analog_power_en,    // Powers the analog core.
  output logic      [2:0]  channel_select,     // Analog multiplexer select.
  output logic             sample_hold,        // High while sampling.
  output logic      [7:0]  dac_code,           // Trial code for the comparator.
  output logic             irq                 // Level interrupt.
);

  // ****************************************************************
  // Decode helper.
  // ****************************************************************

  // Compares the bus address with one register address.
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] target);
    addr_hit = (a == target);
  endfunction : addr_hit

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  localparam int unsigned STAB_W_L = sac_pkg::STAB_W;
  localparam logic [STAB_W_L-1:0] STAB_LAST = STAB_W_L'(STAB_CYCLES - 1);
  sac_pkg::sac_state_type state_q;             // Sequencer state.
  sac_pkg::sac_state_type state_d;             // Next sequencer state.
  logic                   power_on_q;          // converter_power_on bit.
  logic [2:0]             chan_q;              // Channel select bits.
  logic                   complete_q;          // Completion flag.
  logic [7:0]             result_q;            // conversion_result register.
  logic [7:0]             work_q;              // Trial code under test.
  logic [5:0]             phase_q;             // Cycle within a conversion.
  logic [STAB_W_L-1:0]    stab_cnt_q;          // Stabilization counter.
  logic [1:0]             irq_status_q;        // Sticky event bits.
  logic [1:0]             irq_enable_q;        // Event enable bits.
  logic [31:0]            prdata_q;            // Read data captured in setup.
  logic [31:0]            rd_mux;              // Read data selected by address.
  logic                   setup;               // APB setup cycle.
  logic                   access;              // APB access cycle.
  logic                   mapped;              // Address hits a register.
  logic                   wr_ctrl;             // Write to control register.
  logic                   wr_clr;              // Write to event clear register.
  logic                   wr_en;               // Write to event enable register.
  logic                   rd_result;           // Read of result register.
  logic                   pwr_next;            // Power bit after this cycle.
  logic                   run_en;              // Converter allowed to run.
  logic                   active;              // Sampling or converting.
  logic                   abort;               // Running conversion is aborted.
  logic                   stab_done;           // Stabilization time has elapsed.
  logic                   conv_done;           // Last cycle of a conversion.
  logic                   slot_end;            // Last cycle of a trial bit.
  logic [2:0]             slot;                // Trial bit slot, 0 is the MSB.
  logic [7:0]             mask;                // Bit under trial.
  logic [7:0]             decided;             // Code after the current trial.
  logic [1:0]             irq_event;           // Event pulses.

  // ****************************************************************
  // APB slave.
  // ****************************************************************

  // Phase decode; every access is answered in its first access cycle.
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign pready  = access;
  assign prdata  = prdata_q;

  // Address decode against the five registers.
  assign mapped  = addr_hit(paddr, sac_pkg::ADDR_RESULT)
                 | addr_hit(paddr, sac_pkg::ADDR_CONTROL)
                 | addr_hit(paddr, sac_pkg::ADDR_IRQ_STATUS)
                 | addr_hit(paddr, sac_pkg::ADDR_IRQ_CLEAR)
                 | addr_hit(paddr, sac_pkg::ADDR_IRQ_ENABLE);
  assign pslverr = access & ~mapped;

  // Write and read strobes; only byte lane 0 carries register data.
  assign wr_ctrl   = access & pwrite & pstrb[0] & addr_hit(paddr, sac_pkg::ADDR_CONTROL);
  assign wr_clr    = access & pwrite & pstrb[0] & addr_hit(paddr, sac_pkg::ADDR_IRQ_CLEAR);
  assign wr_en     = access & pwrite & pstrb[0] & addr_hit(paddr, sac_pkg::ADDR_IRQ_ENABLE);
  assign rd_result = access & ~pwrite & addr_hit(paddr, sac_pkg::ADDR_RESULT);

  // Read multiplexer; unused bits read zero.
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (addr_hit(paddr, sac_pkg::ADDR_RESULT))
    begin
      rd_mux[7:0] = result_q;
    end
    else if (addr_hit(paddr, sac_pkg::ADDR_CONTROL))
    begin
      // Bits 6, 4 and 3 always read zero.
      rd_mux[sac_pkg::BIT_COMPLETE] = complete_q;
      rd_mux[sac_pkg::BIT_POWER_ON] = power_on_q;
      rd_mux[2:0]                   = chan_q;
    end
    else if (addr_hit(paddr, sac_pkg::ADDR_IRQ_STATUS))
    begin
      rd_mux[1:0] = irq_status_q;
    end
    else if (addr_hit(paddr, sac_pkg::ADDR_IRQ_ENABLE))
    begin
      rd_mux[1:0] = irq_enable_q;
    end
    else
    begin
      rd_mux = 32'h0000_0000;
    end
  end

  // Read data is registered in setup and held; an unmapped access loads zero.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else if (setup && (!pwrite || !mapped))
    begin
      prdata_q <= rd_mux;
    end
  end

  // ****************************************************************
  // Control register.
  // ****************************************************************

  // Power and channel bits are written only by software; writes to
  // the reserved bits are dropped.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      power_on_q <= 1'b0;
      chan_q     <= 3'h0;
    end
    else if (wr_ctrl)
    begin
      power_on_q <= pwdata[sac_pkg::BIT_POWER_ON];
      chan_q     <= pwdata[2:0];
    end
  end

  // Multiplexer only selects; pin input buffers stay with the ports,
  // so a pin used as analog input still reads as logic.
  assign channel_select = chan_q;

  // ****************************************************************
  // Sequencer.
  // ****************************************************************

  // A write that clears the power bit stops the converter at once.
  // Halt stops it too; wait mode has no input here.
  assign pwr_next  = wr_ctrl ? pwdata[sac_pkg::BIT_POWER_ON] : power_on_q;
  assign run_en    = pwr_next & ~halt_mode;
  assign active    = (state_q == sac_pkg::SAC_SAMPLE) | (state_q == sac_pkg::SAC_CONVERT);
  assign abort     = wr_ctrl & active & run_en;
  assign stab_done = (state_q == sac_pkg::SAC_SETTLE) & (stab_cnt_q == STAB_LAST);
  assign conv_done = (state_q == sac_pkg::SAC_CONVERT) & (phase_q == sac_pkg::CONV_LAST)
                   & ~abort & run_en;

  // Next state: settle after every power-up or wake-up, then convert
  // back to back until stopped.
  always_comb
  begin
    state_d = state_q;
    if (!run_en)
    begin
      state_d = sac_pkg::SAC_OFF;
    end
    else
    begin
      case (state_q)
        sac_pkg::SAC_OFF:
          state_d = sac_pkg::SAC_SETTLE;
        sac_pkg::SAC_SETTLE:
          if (stab_done)
          begin
            state_d = sac_pkg::SAC_SAMPLE;
          end
        sac_pkg::SAC_SAMPLE:
          if (!abort && phase_q == sac_pkg::SAMPLE_LAST)
          begin
            state_d = sac_pkg::SAC_CONVERT;
          end
        sac_pkg::SAC_CONVERT:
          if (abort || phase_q == sac_pkg::CONV_LAST)
          begin
            state_d = sac_pkg::SAC_SAMPLE;
          end
        default:
          state_d = sac_pkg::SAC_OFF;
      endcase
    end
  end

  // State register.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= sac_pkg::SAC_OFF;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Stabilization counter runs only while settling.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stab_cnt_q <= '0;
    end
    else if (state_q == sac_pkg::SAC_SETTLE && state_d == sac_pkg::SAC_SETTLE)
    begin
      stab_cnt_q <= stab_cnt_q + 1'b1;
    end
    else
    begin
      stab_cnt_q <= '0;
    end
  end

  // Phase counter: 0..31 sampling, 32..63 eight 4-cycle trials.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phase_q <= 6'h00;
    end
    else if (!active || abort || state_d == sac_pkg::SAC_OFF)
    begin
      phase_q <= 6'h00;
    end
    else
    begin
      phase_q <= phase_q + 6'h01;
    end
  end

  // Analog strobes follow the state register.
  assign analog_power_en = (state_q != sac_pkg::SAC_OFF);
  assign sample_hold     = (state_q == sac_pkg::SAC_SAMPLE);
  assign dac_code        = work_q;

  // ****************************************************************
  // Successive approximation.
  // ****************************************************************

  // Trial slot and the bit it tests.
  assign slot     = phase_q[4:2];
  assign mask     = sac_pkg::TRIAL_FIRST >> slot;
  assign slot_end = (state_q == sac_pkg::SAC_CONVERT) & (phase_q[1:0] == sac_pkg::TRIAL_LAST);
  // Keep the bit when the input is at or above the trial level, so an
  // input at the high reference ends at all ones.
  assign decided  = cmp_above ? work_q : (work_q & ~mask);

  // Trial register; it drives the comparator DAC directly.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      work_q <= 8'h00;
    end
    else if (abort || state_d != sac_pkg::SAC_CONVERT)
    begin
      work_q <= 8'h00;
    end
    else if (state_q == sac_pkg::SAC_SAMPLE)
    begin
      work_q <= sac_pkg::TRIAL_FIRST;
    end
    else if (slot_end)
    begin
      work_q <= decided | (mask >> 1);
    end
  end

  // Result register loads only on completion and otherwise keeps
  // its value, also while switched off.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      result_q <= sac_pkg::RESET_RESULT;
    end
    else if (conv_done)
    begin
      result_q <= decided;
    end
  end

  // Completion flag: set wins over a clear in the same cycle.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      complete_q <= 1'b0;
    end
    else if (conv_done)
    begin
      complete_q <= 1'b1;
    end
    else if (rd_result || wr_ctrl || !power_on_q)
    begin
      complete_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Event interrupts.
  // ****************************************************************

  // Events are stabilization finished and conversion aborted; the
  // completion flag is kept out of the interrupt on purpose.
  assign irq_event[sac_pkg::IRQ_SETTLED] = stab_done & run_en;
  assign irq_event[sac_pkg::IRQ_ABORTED] = abort;

  // One sticky bit per event; a new event wins over a clear.
  for (genvar i = 0; i < sac_pkg::IRQ_W; i++)
  begin : g_irq
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        irq_status_q[i] <= 1'b0;
      end
      else if (irq_event[i])
      begin
        irq_status_q[i] <= 1'b1;
      end
      else if (wr_clr && pwdata[i])
      begin
        irq_status_q[i] <= 1'b0;
      end
    end
  end

  // Enable register.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_enable_q <= 2'h0;
    end
    else if (wr_en)
    begin
      irq_enable_q <= pwdata[1:0];
    end
  end

  // Interrupt is high while any enabled status bit is set.
  assign irq = |(irq_status_q & irq_enable_q);

endmodule : sac_adc_ctrl

`default_nettype wire

// ### verif/sac_adc_ctrl_asserts.sv
// Port checker of the converter control, bound into the control module.
`timescale 1ns/1ps
`default_nettype none

module sac_adc_ctrl_asserts #(
  parameter int unsigned STAB_CYCLES = 8
) (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        halt_mode,
  input wire logic        analog_power_en,
  input wire logic [2:0]  channel_select,
  input wire logic        sample_hold,
  input wire logic [7:0]  dac_code
);
  // ****************************************************************
  // Helper logic.
  // ****************************************************************
  wire logic ctl_wr = psel && penable && pwrite && pstrb[0] && paddr == sac_pkg::ADDR_CONTROL;
  wire logic ctl_rd = psel && penable && !pwrite && paddr == sac_pkg::ADDR_CONTROL;
  wire logic mapped = paddr inside {sac_pkg::ADDR_RESULT, sac_pkg::ADDR_CONTROL,
    sac_pkg::ADDR_IRQ_STATUS, sac_pkg::ADDR_IRQ_CLEAR, sac_pkg::ADDR_IRQ_ENABLE};
  logic [15:0] pw_q;  // Cycles since the analog core powered up.
  logic [5:0]  hi_q;  // Sampling cycles since the last restart.
  logic [5:0]  lo_q;  // Non-sampling cycles since the last sample.

  // Counts the runs of the sequencer outputs; a control write restarts the sampling and non-sampling counts.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pw_q <= 16'h0000;
      hi_q <= 6'h00;
      lo_q <= 6'h00;
    end
    else
    begin
      pw_q <= analog_power_en ? pw_q + 16'(pw_q != 16'hffff) : 16'h0000;
      hi_q <= (ctl_wr || !sample_hold) ? 6'h00 : hi_q + 6'h01;
      lo_q <= (ctl_wr || sample_hold) ? 6'h00 : lo_q + 6'h01;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  AST_SAMPLE_LEN: assert property (
    $fell(sample_hold) && analog_power_en |-> hi_q == 6'h20) else $error("sample length");
  AST_CONV_LEN: assert property (
    $rose(sample_hold) && $past(dac_code) != 8'h00 && !$past(ctl_wr) |-> lo_q == 6'h20)
    else $error("conversion length");
  AST_FIRST_TRIAL: assert property (
    $fell(sample_hold) && analog_power_en |-> dac_code == 8'h80) else $error("first trial");
  AST_SETTLE: assert property (
    $rose(sample_hold) |-> pw_q >= STAB_CYCLES) else $error("settle too short");
  AST_OFF_QUIET: assert property (
    !analog_power_en |-> !sample_hold && dac_code == 8'h00) else $error("active while off");
  AST_HALT: assert property (
    halt_mode ##1 halt_mode |-> !analog_power_en) else $error("halt not off");
  AST_POWER_WR: assert property (
    ctl_wr && !pwdata[5] |=> !analog_power_en) else $error("power bit ignored");
  AST_CHAN: assert property (
    ctl_wr |=> channel_select == $past(pwdata[2:0])) else $error("channel select");
  AST_CTL_READ: assert property (
    ctl_rd |-> prdata[31:8] == 24'h0 && !prdata[6] && prdata[4:3] == 2'h0)
    else $error("reserved bits");
  AST_READY: assert property (psel && penable |-> pready) else $error("wait state");
  AST_UNMAPPED: assert property (
    psel && penable && !mapped |-> pslverr && prdata == 32'h0) else $error("unmapped");
endmodule : sac_adc_ctrl_asserts

bind sac_adc_ctrl sac_adc_ctrl_asserts #(.STAB_CYCLES(STAB_CYCLES)) i_asserts (
  .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .halt_mode(halt_mode),
  .analog_power_en(analog_power_en), .channel_select(channel_select),
  .sample_hold(sample_hold), .dac_code(dac_code));

`default_nettype wire

// ### verif/sac_analog_src.sv
// Model of the analog sources, multiplexer, hold capacitor and comparator.
`timescale 1ns/1ps
`default_nettype none

module sac_analog_src (
  input  wire logic        ref_clk,          // Converter clock.
  input  wire logic        reset_n,          // Asynchronous reset, active low.
  input  wire logic [63:0] levels,           // Level of each input, eight bits each.
  input  wire logic        analog_power_en,  // Analog core powered.
  input  wire logic [2:0]  channel_select,   // Multiplexer select.
  input  wire logic        sample_hold,      // Track while high, hold while low.
  input  wire logic [7:0]  dac_code,         // Trial level.
  output logic             cmp_above         // Held level at or above the trial.
);
  logic [7:0] held_q;   // Level on the hold capacitor.
  logic       toggle_q; // Junk shown by an unpowered comparator.

  // Tracks the selected input while sampling; the junk bit flips every cycle.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      held_q   <= 8'h00;
      toggle_q <= 1'b0;
    end
    else
    begin
      if (sample_hold)
      begin
        held_q <= levels[{channel_select, 3'h0} +: 8];
      end
      toggle_q <= ~toggle_q;
    end
  end

  // A full-scale level stays at or above every trial, so it converts to all ones.
  assign cmp_above = analog_power_en ? (held_q >= dac_code) : toggle_q;
endmodule : sac_analog_src

`default_nettype wire

// ### verif/tb_sar_adc_control_8ch.sv
// Self-checking bench of the converter control with an analog source model.
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module tb_sar_adc_control_8ch;
  localparam int unsigned STAB = 8;  // Short settle time for simulation.
  logic        ref_clk;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        halt_mode;
  logic        cmp_above;
  logic        analog_power_en;
  logic [2:0]  channel_select;
  logic        sample_hold;
  logic [7:0]  dac_code;
  logic        irq;
  logic [63:0] levels;    // Input levels, eight bits a channel.
  logic [63:0] tmp;       // Next set of levels.
  logic [31:0] rd;        // Data of the last read.
  logic        err;       // Error response of the last transfer.
  logic [2:0]  ch;        // Channel under test.
  logic [7:0]  last;      // Result expected to be kept.
  int          failures;
  int          compares;
  int          seed;

  sac_adc_ctrl #(.STAB_CYCLES(STAB)) i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .halt_mode(halt_mode), .cmp_above(cmp_above), .analog_power_en(analog_power_en),
    .channel_select(channel_select), .sample_hold(sample_hold), .dac_code(dac_code),
    .irq(irq));

  sac_analog_src i_src (.ref_clk(ref_clk), .reset_n(reset_n), .levels(levels),
    .analog_power_en(analog_power_en), .channel_select(channel_select),
    .sample_hold(sample_hold), .dac_code(dac_code), .cmp_above(cmp_above));

  // Free-running 200 MHz clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Expected result of a channel: the converter is exact on an ideal source.
  function automatic logic [7:0] lvl(input logic [2:0] c);
    return levels[{c, 3'h0} +: 8];
  endfunction : lvl

  // One APB transfer; holds the request until pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
    begin
      @(posedge ref_clk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Polls the completion flag a bounded number of times.
  task automatic wait_done();
    int n = 0;
    rd = '0;
    while (rd[7] !== 1'b1 && n < 100)
    begin
      apb(1'b0, sac_pkg::ADDR_CONTROL, 32'h0);
      n++;
    end
    `CHK(rd[7], 1'b1)
  endtask : wait_done

  // Prints the verdict and stops.
  task automatic end_of_test();
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  // Cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    end_of_test();
  end

  // Main sequence.
  initial
  begin
    seed = 65998;
    failures = 0;
    compares = 0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    halt_mode = 1'b0;
    levels = 64'h0;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    apb(1'b0, sac_pkg::ADDR_RESULT, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, sac_pkg::ADDR_CONTROL, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 12'h000, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, sac_pkg::ADDR_IRQ_ENABLE, 32'h3);
    // Every channel in turn, then random ones; bit 4 written high, bits 6 and 3 low.
    for (int k = 0; k < 12; k++)
    begin
      ch = (k < 8) ? 3'(k) : 3'($random(seed));
      tmp = {$random(seed), $random(seed)};
      if (k == 0)
        tmp[7:0] = 8'h00;
      if (k == 7)
        tmp[63:56] = 8'hff;
      levels <= tmp;
      apb(1'b1, sac_pkg::ADDR_CONTROL, {24'h0, 5'h06, ch});
      wait_done();
      apb(1'b0, sac_pkg::ADDR_RESULT, 32'h0);
      `CHK(rd, {24'h0, lvl(ch)})
      apb(1'b0, sac_pkg::ADDR_CONTROL, 32'h0);
      `CHK(rd, {24'h0, 5'h04, ch})
    end
    wait_done();
    apb(1'b0, sac_pkg::ADDR_IRQ_STATUS, 32'h0);
    `CHK(rd, 32'h3)
    `CHK(irq, 1'b1)
    apb(1'b1, sac_pkg::ADDR_IRQ_CLEAR, 32'h3);
    wait_done();
    apb(1'b0, sac_pkg::ADDR_IRQ_STATUS, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(irq, 1'b0)
    apb(1'b1, sac_pkg::ADDR_IRQ_ENABLE, 32'h0);
    apb(1'b1, sac_pkg::ADDR_CONTROL, {24'h0, 5'h04, ch});
    apb(1'b0, sac_pkg::ADDR_IRQ_STATUS, 32'h0);
    `CHK(rd, 32'h2)
    `CHK(irq, 1'b0)
    apb(1'b1, sac_pkg::ADDR_IRQ_CLEAR, 32'h3);
    // Halt switches the core off; a fresh settle and conversion follow wake-up.
    halt_mode <= 1'b1;
    repeat (20) @(posedge ref_clk);
    `CHK(analog_power_en, 1'b0)
    apb(1'b0, sac_pkg::ADDR_RESULT, 32'h0);
    halt_mode <= 1'b0;
    wait_done();
    apb(1'b0, sac_pkg::ADDR_RESULT, 32'h0);
    `CHK(rd, {24'h0, lvl(ch)})
    // Power off keeps the last result and the flag stays clear.
    last = lvl(ch);
    apb(1'b1, sac_pkg::ADDR_CONTROL, 32'h05);
    repeat (150) @(posedge ref_clk);
    apb(1'b0, sac_pkg::ADDR_CONTROL, 32'h0);
    `CHK(rd, 32'h05)
    // A write with byte lane 0 off must leave the control register alone.
    pstrb <= 4'he;
    apb(1'b1, sac_pkg::ADDR_CONTROL, 32'h27);
    pstrb <= 4'hf;
    apb(1'b0, sac_pkg::ADDR_CONTROL, 32'h0);
    `CHK(rd, 32'h05)
    apb(1'b1, sac_pkg::ADDR_RESULT, 32'h5a);
    apb(1'b0, sac_pkg::ADDR_RESULT, 32'h0);
    `CHK(rd, {24'h0, last})
    end_of_test();
  end
endmodule : tb_sar_adc_control_8ch

`default_nettype wire
